// ==== logic/acsb_control.v ====
// Converter second control register with sequencing and buffer control
//
// Behaviour
// - Reference field: 000 supply, 001 ext pos, 010 ext neg, 011 both, 1xx supply.
// - Calibration bit set ties both amplifier inputs to low reference.
// - Calibration clear: inputs follow channel and scan selection.
// - Bit 10 set scans selected inputs; clear means no scan.
// - Fill status reads one when filling upper half, zero when lower.
// - Interrupt after every (N+1)th sample/convert sequence.
// - Split bit set: two 8-word halves; clear: one 16-word buffer.
// - Alternate bit set: first set first, then second and first alternate.
// - Alternate bit clear: first multiplexer set for every sample.
// - Bits 31-16, 11, 9-8 and 6 read zero, ignore writes.
//
// Added by the designer: the Avalon-MM slave port and the register addresses.
`timescale 1ns/10ps
`include "acsb_defs.vh"
module acsb_control
#(
	parameter SEQ_WIDTH = 4,
	parameter PTR_WIDTH = 4
)
(
	input wire clock_in,
	input wire reset_in,
	input wire clock_enable_in,
	input wire [3:0] avs_address_in,
	input wire avs_read_in,
	input wire avs_write_in,
	input wire [31:0] avs_writedata_in,
	input wire [3:0] avs_byteenable_in,
	output reg [31:0] avs_readdata_out,
	output reg avs_waitrequest_out,
	input wire sample_done_in,
	input wire sequence_done_in,
	output reg [2:0] high_reference_out,
	output reg [2:0] low_reference_out,
	output reg amp_inputs_to_low_ref_out,
	output reg channel_path_select_out,
	output reg input_scan_enable_out,
	output reg mux_set_b_out,
	output reg buffer_fill_status_out,
	output reg [PTR_WIDTH-1:0] result_write_ptr_out,
	output reg result_write_out,
	output reg irq_out
);
	// ----------------------------------------
	// Control register and interrupt state
	// ----------------------------------------
	reg [2:0] ref_sel_reg;
	reg offset_calibration_enable_reg;
	reg scan_reg;
	reg [SEQ_WIDTH-1:0] seq_limit_reg;
	reg split_reg;
	reg alt_reg;
	reg [`ACSB_ST_WIDTH-1:0] status_reg;
	reg [`ACSB_ST_WIDTH-1:0] mask_reg;
	reg ack_reg;
	wire [31:0] byte_mask;
	wire [31:0] wdata_masked;
	wire boundary;
	wire ctrl_write;
	reg [31:0] ctrl2_view;
	reg [31:0] rdata_next;
	reg [2:0] high_ref_next;
	reg [2:0] low_ref_next;
	reg first_sample_reg;
	wire bus_accept;
	wire status_write;
	wire mask_write;
	genvar b;
	generate
		for (b = 0; b < 4; b = b + 1)
		begin : g_lane
			assign byte_mask[b*8+7:b*8] = {8{avs_byteenable_in[b]}};
		end
	endgenerate
	assign wdata_masked = avs_writedata_in & byte_mask;
	// Writes land on the acknowledge edge, the only edge at which the master sees waitrequest low
	assign bus_accept = avs_write_in && ack_reg;
	assign ctrl_write = bus_accept && (avs_address_in == `ACSB_OFS_CTRL2);
	assign status_write = bus_accept && (avs_address_in == `ACSB_OFS_STATUS) && avs_byteenable_in[0];
	assign mask_write = bus_accept && (avs_address_in == `ACSB_OFS_MASK) && avs_byteenable_in[0];
	// ----------------------------------------
	// Read view of the control register
	// ----------------------------------------
	always @*
	begin
		ctrl2_view = 32'h0000_0000;
		ctrl2_view[`ACSB_REF_HI:`ACSB_REF_LO] = ref_sel_reg;
		ctrl2_view[`ACSB_OFFSET_CALIBRATION_ENABLE_BIT] = offset_calibration_enable_reg;
		ctrl2_view[`ACSB_SCAN_BIT] = scan_reg;
		ctrl2_view[`ACSB_FILL_BIT] = buffer_fill_status_out;
		ctrl2_view[`ACSB_SEQ_HI:`ACSB_SEQ_LO] = seq_limit_reg;
		ctrl2_view[`ACSB_SPLIT_BIT] = split_reg;
		ctrl2_view[`ACSB_ALT_BIT] = alt_reg;
	end
	always @*
	begin
		if (avs_address_in == `ACSB_OFS_CTRL2)
			rdata_next = ctrl2_view;
		else if (avs_address_in == `ACSB_OFS_STATUS)
			rdata_next = {30'h0000_0000, status_reg};
		else if (avs_address_in == `ACSB_OFS_MASK)
			rdata_next = {30'h0000_0000, mask_reg};
		else if (avs_address_in == `ACSB_OFS_POINTER)
			rdata_next = {{(32-PTR_WIDTH){1'b0}}, result_write_ptr_out};
		else
			rdata_next = 32'h0000_0000;
	end
	// ----------------------------------------
	// Bus slave: one wait cycle, then acknowledge
	// ----------------------------------------
	always @(posedge clock_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			ack_reg <= 1'b0;
			avs_waitrequest_out <= 1'b1;
			avs_readdata_out <= 32'h0000_0000;
		end
		else if (clock_enable_in)
		begin
			// Waitrequest is low only in the ack cycle, so each access takes two edges
			if ((avs_read_in || avs_write_in) && !ack_reg)
			begin
				ack_reg <= 1'b1;
				avs_waitrequest_out <= 1'b0;
				avs_readdata_out <= rdata_next;
			end
			else
			begin
				ack_reg <= 1'b0;
				avs_waitrequest_out <= 1'b1;
			end
		end
	end
	// ----------------------------------------
	// Control fields
	// ----------------------------------------
	always @(posedge clock_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			ref_sel_reg <= 3'h0;
			offset_calibration_enable_reg <= 1'b0;
			scan_reg <= 1'b0;
			seq_limit_reg <= {SEQ_WIDTH{1'b0}};
			split_reg <= 1'b0;
			alt_reg <= 1'b0;
			mask_reg <= {`ACSB_ST_WIDTH{1'b0}};
		end
		else if (clock_enable_in)
		begin
			if (ctrl_write)
			begin
				ref_sel_reg <= (wdata_masked[`ACSB_REF_HI:`ACSB_REF_LO] & byte_mask[15:13]) |
					(ref_sel_reg & ~byte_mask[15:13]);
				if (avs_byteenable_in[1])
				begin
					offset_calibration_enable_reg <= avs_writedata_in[`ACSB_OFFSET_CALIBRATION_ENABLE_BIT];
					scan_reg <= avs_writedata_in[`ACSB_SCAN_BIT];
				end
				if (avs_byteenable_in[0])
				begin
					seq_limit_reg <= avs_writedata_in[`ACSB_SEQ_HI:`ACSB_SEQ_LO];
					split_reg <= avs_writedata_in[`ACSB_SPLIT_BIT];
					alt_reg <= avs_writedata_in[`ACSB_ALT_BIT];
				end
			end
			if (mask_write)
				mask_reg <= avs_writedata_in[`ACSB_ST_WIDTH-1:0];
		end
	end
	// ----------------------------------------
	// Sequence counting
	// ----------------------------------------
	acsb_seq_counter #(
		.WIDTH(SEQ_WIDTH)
	) u_seq (
		.clock_in(clock_in),
		.reset_in(reset_in),
		.enable_in(clock_enable_in),
		.clear_in(ctrl_write),
		.done_in(sequence_done_in),
		.limit_in(seq_limit_reg),
		.boundary_out(boundary)
	);
	// ----------------------------------------
	// Buffer pointer and multiplexer alternation
	// ----------------------------------------
	always @(posedge clock_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			first_sample_reg <= 1'b1;
			mux_set_b_out <= 1'b0;
			buffer_fill_status_out <= 1'b0;
			result_write_ptr_out <= {PTR_WIDTH{1'b0}};
			result_write_out <= 1'b0;
		end
		else if (clock_enable_in)
		begin
			result_write_out <= sample_done_in;
			// Rewriting the control register restarts the sequence from sample A
			if (ctrl_write)
			begin
				first_sample_reg <= 1'b1;
				mux_set_b_out <= 1'b0;
				buffer_fill_status_out <= 1'b0;
				result_write_ptr_out <= {PTR_WIDTH{1'b0}};
			end
			else
			begin
				if (sample_done_in)
				begin
					first_sample_reg <= 1'b0;
					if (alt_reg)
						mux_set_b_out <= first_sample_reg ? 1'b1 : ~mux_set_b_out;
					else
						mux_set_b_out <= 1'b0;
					// Split mode keeps the top pointer bit equal to the fill status
					if (split_reg)
						result_write_ptr_out <= {buffer_fill_status_out, result_write_ptr_out[PTR_WIDTH-2:0] +
							{{(PTR_WIDTH-2){1'b0}}, 1'b1}};
					else
						result_write_ptr_out <= result_write_ptr_out + {{(PTR_WIDTH-1){1'b0}}, 1'b1};
				end
				if (boundary && split_reg)
				begin
					buffer_fill_status_out <= ~buffer_fill_status_out;
					result_write_ptr_out <= {~buffer_fill_status_out, {(PTR_WIDTH-1){1'b0}}};
				end
				else if (boundary)
					result_write_ptr_out <= {PTR_WIDTH{1'b0}};
			end
		end
	end
	// ----------------------------------------
	// Event status and interrupt
	// ----------------------------------------
	always @(posedge clock_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			status_reg <= {`ACSB_ST_WIDTH{1'b0}};
			irq_out <= 1'b0;
		end
		else if (clock_enable_in)
		begin
			// Set wins over a simultaneous write-one clear
			status_reg[`ACSB_ST_SEQ_IRQ] <= boundary |
				(status_reg[`ACSB_ST_SEQ_IRQ] & ~(status_write & avs_writedata_in[`ACSB_ST_SEQ_IRQ]));
			status_reg[`ACSB_ST_HALF_SWAP] <= (boundary & split_reg) |
				(status_reg[`ACSB_ST_HALF_SWAP] & ~(status_write & avs_writedata_in[`ACSB_ST_HALF_SWAP]));
			// Registered, so the line follows the status one cycle late
			irq_out <= |(status_reg & mask_reg);
		end
	end
	// ----------------------------------------
	// Reference decode
	// ----------------------------------------
	always @*
	begin
		high_ref_next = `ACSB_REF_SUPPLY;
		low_ref_next = `ACSB_REF_SUPPLY;
		case (ref_sel_reg)
			`ACSB_REF_EXT_POS:
				high_ref_next = `ACSB_REF_EXT_POS;
			`ACSB_REF_EXT_NEG:
				low_ref_next = `ACSB_REF_EXT_NEG;
			`ACSB_REF_EXT_BOTH:
			begin
				high_ref_next = `ACSB_REF_EXT_POS;
				low_ref_next = `ACSB_REF_EXT_NEG;
			end
			default:
			begin
				high_ref_next = `ACSB_REF_SUPPLY;
				low_ref_next = `ACSB_REF_SUPPLY;
			end
		endcase
	end
	// ----------------------------------------
	// Analog steering outputs
	// ----------------------------------------
	always @(posedge clock_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			high_reference_out <= `ACSB_REF_SUPPLY;
			low_reference_out <= `ACSB_REF_SUPPLY;
			amp_inputs_to_low_ref_out <= 1'b0;
			channel_path_select_out <= 1'b1;
			input_scan_enable_out <= 1'b0;
		end
		else if (clock_enable_in)
		begin
			high_reference_out <= high_ref_next;
			low_reference_out <= low_ref_next;
			// Calibration overrides scanning so no channel reaches the amplifier meanwhile
			amp_inputs_to_low_ref_out <= offset_calibration_enable_reg;
			channel_path_select_out <= ~offset_calibration_enable_reg;
			input_scan_enable_out <= scan_reg & ~offset_calibration_enable_reg;
		end
	end
endmodule

// ==== logic/acsb_defs.vh ====
// Constants for the converter control block: offsets, fields, reset values
`ifndef ACSB_DEFS_VH
`define ACSB_DEFS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ACSB_OFS_CTRL2 4'h0
`define ACSB_OFS_STATUS 4'h4
`define ACSB_OFS_MASK 4'h8
`define ACSB_OFS_POINTER 4'hc
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define ACSB_REF_HI 15
`define ACSB_REF_LO 13
`define ACSB_OFFSET_CALIBRATION_ENABLE_BIT 12
`define ACSB_SCAN_BIT 10
`define ACSB_FILL_BIT 7
`define ACSB_SEQ_HI 5
`define ACSB_SEQ_LO 2
`define ACSB_SPLIT_BIT 1
`define ACSB_ALT_BIT 0
`define ACSB_CTRL2_WMASK 32'h0000_f43f
`define ACSB_CTRL2_RESET 32'h0000_0000
// ----------------------------------------
// Reference selection codes
// ----------------------------------------
`define ACSB_REF_SUPPLY 3'h0
`define ACSB_REF_EXT_POS 3'h1
`define ACSB_REF_EXT_NEG 3'h2
`define ACSB_REF_EXT_BOTH 3'h3
// ----------------------------------------
// Status bits
// ----------------------------------------
`define ACSB_ST_SEQ_IRQ 0
`define ACSB_ST_HALF_SWAP 1
`define ACSB_ST_WIDTH 2
`endif

// ==== logic/acsb_seq_counter.v ====
// Sequence counter that flags every (N+1)th completed sequence
`timescale 1ns/10ps
`include "acsb_defs.vh"
module acsb_seq_counter
#(
	parameter WIDTH = 4
)
(
	input wire clock_in,
	input wire reset_in,
	input wire enable_in,
	input wire clear_in,
	input wire done_in,
	input wire [WIDTH-1:0] limit_in,
	output reg boundary_out
);
	reg [WIDTH-1:0] count_reg;
	always @(posedge clock_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			count_reg <= {WIDTH{1'b0}};
			boundary_out <= 1'b0;
		end
		else if (enable_in)
		begin
			boundary_out <= 1'b0;
			if (clear_in)
				count_reg <= {WIDTH{1'b0}};
			else if (done_in)
			begin
				if (count_reg >= limit_in)
				begin
					count_reg <= {WIDTH{1'b0}};
					boundary_out <= 1'b1;
				end
				else
					count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule

// ==== test/acsb_control_checker.sv ====
// Assertion checker for the converter control block
`timescale 1ns/10ps
module acsb_control_checker
#(
	parameter SEQ_WIDTH = 4,
	parameter PTR_WIDTH = 4
)
(
	input wire clock_in,
	input wire reset_in,
	input wire clock_enable_in,
	input wire avs_read_in,
	input wire avs_write_in,
	input wire [31:0] avs_readdata_out,
	input wire avs_waitrequest_out,
	input wire sample_done_in,
	input wire [2:0] high_reference_out,
	input wire [2:0] low_reference_out,
	input wire amp_inputs_to_low_ref_out,
	input wire channel_path_select_out,
	input wire input_scan_enable_out,
	input wire mux_set_b_out,
	input wire buffer_fill_status_out,
	input wire [PTR_WIDTH-1:0] result_write_ptr_out,
	input wire result_write_out
);
// ----------------------------------------
// Properties
// ----------------------------------------
default clocking cb @(posedge clock_in); endclocking
default disable iff (reset_in);
property p_cal; amp_inputs_to_low_ref_out |-> !channel_path_select_out && !input_scan_enable_out; endproperty
a_cal: assert property (p_cal) else $error("calibration routing wrong");
property p_chan; !amp_inputs_to_low_ref_out |-> channel_path_select_out; endproperty
a_chan: assert property (p_chan) else $error("channel routing wrong");
property p_refs; high_reference_out inside {3'h0, 3'h1} && low_reference_out inside {3'h0, 3'h2}; endproperty
a_refs: assert property (p_refs) else $error("reference code wrong");
property p_ack_one; !avs_waitrequest_out |=> avs_waitrequest_out; endproperty
a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
property p_ack_due; (avs_read_in || avs_write_in) && avs_waitrequest_out && clock_enable_in |=> !avs_waitrequest_out; endproperty
a_ack_due: assert property (p_ack_due) else $error("ack late");
property p_zero_bits; !avs_waitrequest_out |-> (avs_readdata_out & ~32'h0000_f4bf) == 32'h0; endproperty
a_zero_bits: assert property (p_zero_bits) else $error("unimplemented bit set");
property p_swap; $changed(buffer_fill_status_out) |-> result_write_ptr_out == {buffer_fill_status_out, {(PTR_WIDTH-1){1'b0}}}; endproperty
a_swap: assert property (p_swap) else $error("half swap pointer wrong");
property p_wr; clock_enable_in |=> result_write_out == $past(sample_done_in); endproperty
a_wr: assert property (p_wr) else $error("result write not delayed by one");
property p_alt; $rose(mux_set_b_out) |-> $past(sample_done_in); endproperty
a_alt: assert property (p_alt) else $error("mux set changed without sample");
endmodule
bind acsb_control acsb_control_checker #(.SEQ_WIDTH(SEQ_WIDTH), .PTR_WIDTH(PTR_WIDTH)) acsb_control_checker_inst
	(.clock_in(clock_in), .reset_in(reset_in), .clock_enable_in(clock_enable_in), .avs_read_in(avs_read_in),
	.avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
	.sample_done_in(sample_done_in), .high_reference_out(high_reference_out), .low_reference_out(low_reference_out),
	.amp_inputs_to_low_ref_out(amp_inputs_to_low_ref_out), .channel_path_select_out(channel_path_select_out),
	.input_scan_enable_out(input_scan_enable_out), .mux_set_b_out(mux_set_b_out),
	.buffer_fill_status_out(buffer_fill_status_out), .result_write_ptr_out(result_write_ptr_out),
	.result_write_out(result_write_out));

// ==== test/testbench.sv ====
// Self-checking bench for the converter control block
`timescale 1ns/10ps
`include "acsb_defs.vh"
module testbench;
// ----------------------------------------
// Stimulus and checks
// ----------------------------------------
reg clk = 1'b0, rst = 1'b1, ce = 1'b1, rd = 1'b0, wr = 1'b0, sd = 1'b0, qd = 1'b0;
reg [3:0] adr = 4'h0, be = 4'hf;
reg [31:0] wd = 32'h0, q;
wire [31:0] rdata;
wire wreq, cal, chp, scn, muxb, fill, rwr, irq;
wire [2:0] hi, lo;
wire [3:0] ptr;
integer fails = 0, n_checks = 0, i;
always #25 clk = ~clk;
acsb_control acsb_control_inst (.clock_in(clk), .reset_in(rst), .clock_enable_in(ce), .avs_address_in(adr),
	.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be), .avs_readdata_out(rdata),
	.avs_waitrequest_out(wreq), .sample_done_in(sd), .sequence_done_in(qd), .high_reference_out(hi),
	.low_reference_out(lo), .amp_inputs_to_low_ref_out(cal), .channel_path_select_out(chp),
	.input_scan_enable_out(scn), .mux_set_b_out(muxb), .buffer_fill_status_out(fill),
	.result_write_ptr_out(ptr), .result_write_out(rwr), .irq_out(irq));
task chk(input logic [31:0] got, input logic [31:0] exp);
	n_checks = n_checks + 1;
	if (got !== exp)
	begin
		fails = fails + 1;
		$display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
	end
endtask
// Holds the request until waitrequest is seen low
task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
	@(posedge clk);
	adr <= a;
	wr <= w;
	rd <= !w;
	wd <= d;
	// Only the watchdog ends a wait that never gets its answer
	do
		@(posedge clk);
	while (wreq !== 1'b0);
	q = rdata;
	rd <= 1'b0;
	wr <= 1'b0;
endtask
// Samples outputs away from the edge that launches them
task look(input integer n);
	repeat (n) @(posedge clk);
	@(negedge clk);
endtask
task pulse(input integer which, input integer cnt);
	repeat (cnt)
	begin
		@(posedge clk);
		sd <= (which == 0);
		qd <= (which == 1);
		@(posedge clk);
		sd <= 1'b0;
		qd <= 1'b0;
	end
	repeat (5) @(posedge clk);
endtask
task t_reset;
	bus(0, `ACSB_OFS_CTRL2, 32'h0);
	chk(q, `ACSB_CTRL2_RESET);
	chk({hi, lo, cal, chp, scn, muxb, fill, irq}, 32'h10);
endtask
task t_fields;
	for (i = 0; i < 8; i = i + 1)
	begin
		bus(1, `ACSB_OFS_CTRL2, i << 13);
		look(1);
		chk({hi, lo}, {((i == 1 || i == 3) ? 3'h1 : 3'h0), ((i == 2 || i == 3) ? 3'h2 : 3'h0)});
	end
	bus(1, `ACSB_OFS_CTRL2, 32'hffff_ffff);
	bus(0, `ACSB_OFS_CTRL2, 32'h0);
	chk(q, 32'h0000_f43f);
	chk({cal, chp, scn}, 3'b100);
	bus(1, `ACSB_OFS_CTRL2, 32'h400);
	look(1);
	chk({cal, chp, scn}, 3'b011);
	bus(0, 4'h2, 32'h0);
	chk(q, 32'h0);
	bus(1, `ACSB_OFS_POINTER, 32'hf);
	bus(0, `ACSB_OFS_POINTER, 32'h0);
	chk(q, 32'h0);
endtask
task t_split;
	bus(1, `ACSB_OFS_MASK, 32'h3);
	bus(1, `ACSB_OFS_CTRL2, 32'h0a);
	pulse(1, 2);
	chk(irq, 1'b0);
	pulse(1, 1);
	chk(irq, 1'b1);
	chk({fill, ptr}, 5'h18);
	bus(0, `ACSB_OFS_CTRL2, 32'h0);
	chk(q, 32'h0000_008a);
	pulse(0, 9);
	chk({fill, ptr}, 5'h19);
	bus(0, `ACSB_OFS_STATUS, 32'h0);
	chk(q, 32'h3);
	bus(1, `ACSB_OFS_MASK, 32'h0);
	repeat (2) @(posedge clk);
	chk(irq, 1'b0);
	bus(1, `ACSB_OFS_MASK, 32'h3);
	repeat (2) @(posedge clk);
	chk(irq, 1'b1);
	bus(1, `ACSB_OFS_STATUS, 32'h3);
	repeat (2) @(posedge clk);
	chk(irq, 1'b0);
endtask
task t_single;
	bus(1, `ACSB_OFS_CTRL2, 32'h3c);
	pulse(1, 15);
	chk(irq, 1'b0);
	pulse(1, 1);
	chk(irq, 1'b1);
	chk({fill, ptr}, 5'h0);
	bus(1, `ACSB_OFS_STATUS, 32'h3);
	bus(1, `ACSB_OFS_CTRL2, 32'h0);
	pulse(0, 9);
	chk({muxb, ptr}, 5'h9);
	bus(1, `ACSB_OFS_CTRL2, 32'h1);
	look(1);
	chk(muxb, 1'b0);
	pulse(0, 1);
	chk(muxb, 1'b1);
	pulse(0, 1);
	chk(muxb, 1'b0);
	// Clock enable low must freeze pointer and multiplexer
	ce <= 1'b0;
	pulse(0, 2);
	chk({muxb, ptr}, 5'h2);
	ce <= 1'b1;
endtask
task report_and_stop;
	$display("checks %0d mismatches %0d", n_checks, fails);
	if (fails == 0 && n_checks > 0)
		$display("bench passed");
	else
		$display("bench failed");
	$finish;
endtask
initial
begin
	repeat (4) @(posedge clk);
	rst <= 1'b0;
	t_reset;
	t_fields;
	t_split;
	t_single;
	report_and_stop;
end
// Whole run needs well under the 20000 clock cycles this delay allows
initial
begin
	#1000000;
	fails = fails + 1;
	report_and_stop;
end
endmodule
